/* File: src/retr_regs.sv */
// rail enable and trim register bank behind a two-wire control port
//
// Operation
// - enable bit 5 selects trim versus nominal
// - enable bits 4..2 request bucks one to three
// - enable bits 1..0 switch port supplies on
// - buck runs when register bit or pin high
// - trim bits 3:2 set second buck level
// - trim bits 1:0 set third buck level
// - trim applies only with pin or bit set
// - reading first flag register clears all its fault flags
// - reading second clears only under-voltage bits
// - interrupt released once all flags are clear
`timescale 1ns/1ps
module retr_regs
  import retr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = retr_pkg::DEF_DEV_ADDR  // arbitrary default
) (
  // clock, reset, enable
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  // two-wire control port, open drain data
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_drive_n_o,
  // external pins
  input  wire logic                          first_buck_pin_i,
  input  wire logic                          second_buck_pin_i,
  input  wire logic                          third_buck_pin_i,
  input  wire logic                          trim_apply_pin_i,
  // internal event and status sources
  input  wire logic [7:0]                    fault_event_i,
  input  wire logic [retr_pkg::BUCK_COUNT-1:0] undervolt_event_i,
  input  wire logic [retr_pkg::BUCK_COUNT-1:0] power_good_i,
  // rail controls
  output logic                               first_buck_on_o,
  output logic                               second_buck_on_o,
  output logic                               third_buck_on_o,
  output logic                               first_port_switch_on_o,
  output logic                               second_port_switch_on_o,
  output logic [1:0]                         second_buck_trim_code_o,
  output logic [1:0]                         third_buck_trim_code_o,
  // open drain interrupt
  output logic                               int_o,
  output logic                               int_drive_n_o
);

  import retr_pkg::*;

  logic [PIN_COUNT-1:0] pins;
  logic                 scl;
  logic                 sda;
  logic                 prev_scl;
  logic                 prev_sda;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_seen;
  logic                 stop_seen;

  retr_state_e state;
  retr_state_e next_state;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        have_ptr;
  logic        next_have_ptr;
  logic        rw;
  logic        next_rw;
  logic        next_sda_drive_n;
  logic        rd_take;
  logic        wr_en;
  logic [7:0]  rd_data;

  logic [7:0]  enable_reg;
  logic [7:0]  next_enable_reg;
  logic [7:0]  trim_reg;
  logic [7:0]  next_trim_reg;
  logic [7:0]  flags1;
  logic [7:0]  next_flags1;
  logic [BUCK_COUNT-1:0] uvd;
  logic [BUCK_COUNT-1:0] next_uvd;
  logic [BUCK_COUNT-1:0] pg;
  logic [BUCK_COUNT-1:0] next_pg;

  logic        next_first_buck;
  logic        next_second_buck;
  logic        next_third_buck;
  logic        trim_apply;
  logic [1:0]  next_trim2;
  logic [1:0]  next_trim3;
  logic        next_int_drive_n;

  // all asynchronous pins through the three-stage filter
  retr_sync #(
    .WIDTH   (PIN_COUNT),
    .RST_VAL (PIN_IDLE)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_i   ({third_buck_pin_i, second_buck_pin_i, first_buck_pin_i,
                trim_apply_pin_i, sda_i, scl_i}),
    .level_o (pins)
  );

  // bus line events
  assign scl        = pins[PIN_SCL];
  assign sda        = pins[PIN_SDA];
  assign scl_rise   = scl & ~prev_scl;
  assign scl_fall   = ~scl & prev_scl;
  assign start_seen = scl & prev_scl & prev_sda & ~sda;
  assign stop_seen  = scl & prev_scl & ~prev_sda & sda;
  assign rd_take    = scl_fall & ~start_seen & ~stop_seen
                      & (((state == ST_ACK_ADDR) & rw) | (state == ST_RD_LOAD));

  // read mux, unmapped offsets read zero
  always_comb begin
    case (ptr)
      ADDR_ENABLE: rd_data = enable_reg;
      ADDR_TRIM:   rd_data = trim_reg;
      ADDR_FLAGS1: rd_data = flags1;
      ADDR_FLAGS2: rd_data = {FLAGS2_UNUSED, uvd, pg};
      default:     rd_data = READ_ZERO;
    endcase
  end

  // control port sequencer: address, pointer byte, data bytes
  always_comb begin
    next_state       = state;
    next_shift       = shift;
    next_bit_cnt     = bit_cnt;
    next_ptr         = ptr;
    next_have_ptr    = have_ptr;
    next_rw          = rw;
    next_sda_drive_n = sda_drive_n_o;
    wr_en            = 1'b0;
    if (start_seen) begin
      next_state       = ST_ADDR;
      next_bit_cnt     = BIT_ZERO;
      next_have_ptr    = 1'b0;
      next_sda_drive_n = 1'b1;
    end else if (stop_seen) begin
      next_state       = ST_IDLE;
      next_sda_drive_n = 1'b1;
    end else if (rd_take) begin
      next_shift       = rd_data;
      next_sda_drive_n = rd_data[7];
      next_ptr         = 8'(ptr + 8'h01);
      next_bit_cnt     = BIT_ZERO;
      next_state       = ST_RD;
    end else begin
      unique case (state)
        ST_IDLE, ST_RD_LOAD: begin
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda};
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == LAST_BIT) begin
              next_state = (state == ST_ADDR) ? ST_ADDR_CHK : ST_WR_CHK;
            end
          end
        end
        ST_ADDR_CHK: begin
          if (scl_fall) begin
            if (shift[7:1] == DEV_ADDR) begin
              next_sda_drive_n = 1'b0;
              next_rw          = shift[0];
              next_state       = ST_ACK_ADDR;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            next_sda_drive_n = 1'b1;
            next_state       = ST_WR;
          end
        end
        ST_WR_CHK: begin
          if (scl_fall) begin
            next_sda_drive_n = 1'b0;
            next_state       = ST_ACK_WR;
            if (have_ptr) begin
              wr_en    = 1'b1;
              next_ptr = 8'(ptr + 8'h01);
            end else begin
              next_ptr      = shift;
              next_have_ptr = 1'b1;
            end
          end
        end
        ST_ACK_WR: begin
          if (scl_fall) begin
            next_sda_drive_n = 1'b1;
            next_state       = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt == LAST_BIT) begin
              next_sda_drive_n = 1'b1;
              next_state       = ST_RD_ACK;
            end else begin
              next_bit_cnt     = 3'(bit_cnt + 3'h1);
              next_shift       = {shift[6:0], 1'b0};
              next_sda_drive_n = shift[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_state = sda ? ST_IDLE : ST_RD_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state         <= ST_IDLE;
      shift         <= READ_ZERO;
      bit_cnt       <= BIT_ZERO;
      ptr           <= ADDR_ENABLE;
      have_ptr      <= 1'b0;
      rw            <= 1'b0;
      prev_scl      <= 1'b1;
      prev_sda      <= 1'b1;
      sda_drive_n_o <= 1'b1;
      sda_o         <= 1'b0;
    end else if (ce_i) begin
      state         <= next_state;
      shift         <= next_shift;
      bit_cnt       <= next_bit_cnt;
      ptr           <= next_ptr;
      have_ptr      <= next_have_ptr;
      rw            <= next_rw;
      prev_scl      <= scl;
      prev_sda      <= sda;
      sda_drive_n_o <= next_sda_drive_n;
      sda_o         <= 1'b0;
    end
  end

  // register file: writes, sticky flags, clear on read
  always_comb begin
    next_enable_reg = enable_reg;
    next_trim_reg   = trim_reg;
    if (wr_en && ptr == ADDR_ENABLE) begin
      next_enable_reg = shift;
    end
    if (wr_en && ptr == ADDR_TRIM) begin
      next_trim_reg = shift;
    end
    // new events win over a clear in the same cycle
    if (rd_take && ptr == ADDR_FLAGS1) begin
      next_flags1 = fault_event_i;
    end else begin
      next_flags1 = flags1 | fault_event_i;
    end
    if (rd_take && ptr == ADDR_FLAGS2) begin
      next_uvd = undervolt_event_i;
    end else begin
      next_uvd = uvd | undervolt_event_i;
    end
    next_pg = power_good_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= RST_ENABLE;
      trim_reg   <= RST_TRIM;
      flags1     <= RST_FLAGS1;
      uvd        <= RST_UVD;
      pg         <= RST_PG;
    end else if (ce_i) begin
      enable_reg <= next_enable_reg;
      trim_reg   <= next_trim_reg;
      flags1     <= next_flags1;
      uvd        <= next_uvd;
      pg         <= next_pg;
    end
  end

  // rail controls and interrupt
  always_comb begin
    next_first_buck  = enable_reg[BIT_FIRST_BUCK] | pins[PIN_BUCK1];
    next_second_buck = enable_reg[BIT_SECOND_BUCK] | pins[PIN_BUCK2];
    next_third_buck  = enable_reg[BIT_THIRD_BUCK] | pins[PIN_BUCK3];
    trim_apply       = enable_reg[BIT_TRIM_APPLY] | pins[PIN_APPLY];
    next_trim2       = trim_apply ? trim_reg[TRIM2_HI:TRIM2_LO] : TRIM_NOMINAL;
    next_trim3       = trim_apply ? trim_reg[TRIM3_HI:TRIM3_LO] : TRIM_NOMINAL;
    next_int_drive_n = ~((|next_flags1) | (|next_uvd));
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      first_buck_on_o         <= 1'b0;
      second_buck_on_o        <= 1'b0;
      third_buck_on_o         <= 1'b0;
      first_port_switch_on_o  <= 1'b0;
      second_port_switch_on_o <= 1'b0;
      second_buck_trim_code_o <= TRIM_NOMINAL;
      third_buck_trim_code_o  <= TRIM_NOMINAL;
      int_drive_n_o           <= 1'b1;
      int_o                   <= 1'b0;
    end else if (ce_i) begin
      first_buck_on_o         <= next_first_buck;
      second_buck_on_o        <= next_second_buck;
      third_buck_on_o         <= next_third_buck;
      first_port_switch_on_o  <= enable_reg[BIT_FIRST_PORT];
      second_port_switch_on_o <= enable_reg[BIT_SECOND_PORT];
      second_buck_trim_code_o <= next_trim2;
      third_buck_trim_code_o  <= next_trim3;
      int_drive_n_o           <= next_int_drive_n;
      int_o                   <= 1'b0;
    end
  end

endmodule

/* File: src/retr_pkg.sv */
// constants and types shared by the rail enable and trim register bank
package retr_pkg;

  // register offsets on the control port
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_TRIM   = 8'h01;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h02;
  localparam logic [7:0] ADDR_FLAGS2 = 8'h03;

  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_TRIM   = 8'h00;
  localparam logic [7:0] RST_FLAGS1 = 8'h00;
  localparam logic [2:0] RST_UVD    = 3'h0;
  localparam logic [2:0] RST_PG     = 3'h0;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // enable register field positions
  localparam int BIT_TRIM_APPLY  = 5;
  localparam int BIT_FIRST_BUCK  = 4;
  localparam int BIT_SECOND_BUCK = 3;
  localparam int BIT_THIRD_BUCK  = 2;
  localparam int BIT_FIRST_PORT  = 1;
  localparam int BIT_SECOND_PORT = 0;

  // trim register field positions
  localparam int TRIM2_HI = 3;
  localparam int TRIM2_LO = 2;
  localparam int TRIM3_HI = 1;
  localparam int TRIM3_LO = 0;

  // trim codes
  localparam logic [1:0] TRIM_NOMINAL  = 2'h0;
  localparam logic [1:0] TRIM_MINUS_5  = 2'h1;
  localparam logic [1:0] TRIM_MINUS_10 = 2'h2;
  localparam logic [1:0] TRIM_MINUS_15 = 2'h3;

  // second flag register: unused top, under-voltage, power good
  localparam logic [1:0] FLAGS2_UNUSED = 2'h0;
  localparam int         BUCK_COUNT    = 3;

  // synchronised pin vector layout and idle levels
  localparam int         PIN_SCL    = 0;
  localparam int         PIN_SDA    = 1;
  localparam int         PIN_APPLY  = 2;
  localparam int         PIN_BUCK1  = 3;
  localparam int         PIN_BUCK2  = 4;
  localparam int         PIN_BUCK3  = 5;
  localparam int         PIN_COUNT  = 6;
  localparam logic [5:0] PIN_IDLE   = 6'h03;

  // control port
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] BIT_ZERO     = 3'h0;
  localparam logic [6:0] DEF_DEV_ADDR = 7'h2A;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_CHK, ST_ACK_ADDR, ST_WR,
    ST_WR_CHK, ST_ACK_WR, ST_RD, ST_RD_ACK, ST_RD_LOAD
  } retr_state_e;

endpackage

/* File: src/retr_sync.sv */
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module retr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // pins in, filtered levels out
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // per bit: take stage three only when it matches stage two
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_o[i];
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage1  <= RST_VAL;
      stage2  <= RST_VAL;
      stage3  <= RST_VAL;
      level_o <= RST_VAL;
    end else if (ce_i) begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= next_level;
    end
  end

endmodule

/* File: tb/retr_regs_sva.sv */
// port assertions for the rail enable and trim register bank
`timescale 1ns/1ps
module retr_regs_sva (
  // clock, reset, bus
  input wire logic       clock_i, rst_i, ce_i, scl_i, sda_i, sda_o, sda_drive_n_o,
  // pins and events
  input wire logic       first_buck_pin_i, second_buck_pin_i, third_buck_pin_i,
  input wire logic       trim_apply_pin_i,
  input wire logic [7:0] fault_event_i,
  input wire logic [2:0] undervolt_event_i, power_good_i,
  // rail controls and interrupt
  input wire logic       first_buck_on_o, second_buck_on_o, third_buck_on_o,
  input wire logic       first_port_switch_on_o, second_port_switch_on_o,
  input wire logic [1:0] second_buck_trim_code_o, third_buck_trim_code_o,
  input wire logic       int_o, int_drive_n_o
);
  default clocking @(posedge clock_i); endclocking
  // a frozen clock enable holds all state, so nothing is checked meanwhile
  default disable iff (rst_i || !ce_i);
  // a pin held long enough to clear the filter
  sequence s_held(p);
    p [*8];
  endsequence
  // bus clock high long enough that no read load is in flight
  sequence s_quiet_pending;
    (scl_i && !int_drive_n_o) [*8];
  endsequence
  property p_or(p, o);
    s_held(p) |-> o;
  endproperty
  a_first_buck_or: assert property (p_or(first_buck_pin_i, first_buck_on_o))
    else $error("first buck off with its pin high");
  a_second_buck_or: assert property (p_or(second_buck_pin_i, second_buck_on_o))
    else $error("second buck off with its pin high");
  a_third_buck_or: assert property (p_or(third_buck_pin_i, third_buck_on_o))
    else $error("third buck off with its pin high");
  a_fault_raises_int: assert property ((|fault_event_i) |-> ##[1:2] !int_drive_n_o)
    else $error("fault flag did not pull interrupt");
  a_uvd_raises_int: assert property ((|undervolt_event_i) |-> ##[1:2] !int_drive_n_o)
    else $error("under-voltage flag did not pull interrupt");
  a_int_holds_idle: assert property (s_quiet_pending |=> !int_drive_n_o)
    else $error("interrupt released without a read");
  a_reset_rails_off: assert property ($fell(rst_i) |-> !first_port_switch_on_o
      && !second_port_switch_on_o && second_buck_trim_code_o == 2'h0)
    else $error("rails not off after reset");
  a_od_values_low: assert property (!int_o && !sda_o)
    else $error("open drain value not low");
  a_sda_turn_low: assert property ($changed(sda_drive_n_o) |-> !scl_i)
    else $error("data line changed while bus clock high");
endmodule
bind retr_regs retr_regs_sva u_sva (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_drive_n_o(sda_drive_n_o),
  .first_buck_pin_i(first_buck_pin_i), .second_buck_pin_i(second_buck_pin_i),
  .third_buck_pin_i(third_buck_pin_i), .trim_apply_pin_i(trim_apply_pin_i),
  .fault_event_i(fault_event_i), .undervolt_event_i(undervolt_event_i),
  .power_good_i(power_good_i), .first_buck_on_o(first_buck_on_o),
  .second_buck_on_o(second_buck_on_o), .third_buck_on_o(third_buck_on_o),
  .first_port_switch_on_o(first_port_switch_on_o),
  .second_port_switch_on_o(second_port_switch_on_o),
  .second_buck_trim_code_o(second_buck_trim_code_o),
  .third_buck_trim_code_o(third_buck_trim_code_o),
  .int_o(int_o), .int_drive_n_o(int_drive_n_o));

/* File: tb/retr_host.sv */
// host model driving the two-wire control port
`timescale 1ns/1ps
module retr_host #(
  parameter logic [6:0] ADDR = 7'h2A  // arbitrary, matches the bank default
) (
  // clock and resolved data line
  input  wire logic clock_i,
  input  wire logic sda_i,
  // bus clock and data pull
  output logic      scl_o,
  output logic      sda_pull_o
);
  logic [6:0] addr = ADDR;
  logic       s;
  // idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one bit: data set in low phase, sampled at end of high phase
  task xfer(input logic b);
    cyc(3);
    sda_pull_o = !b;
    cyc(8);
    scl_o = 1'b1;
    cyc(10);
    s = sda_i;
    scl_o = 1'b0;
  endtask
  // start or repeated start
  task start;
    if (!scl_o) begin
      cyc(3);
      sda_pull_o = 1'b0;
      cyc(8);
      scl_o = 1'b1;
    end
    cyc(10);
    sda_pull_o = 1'b1;
    cyc(10);
    scl_o = 1'b0;
  endtask
  task stop;
    cyc(3);
    sda_pull_o = 1'b1;
    cyc(8);
    scl_o = 1'b1;
    cyc(10);
    sda_pull_o = 1'b0;
    cyc(10);
  endtask
  task byte_out(input logic [7:0] d, inout logic ok);
    for (int i = 7; i >= 0; i--) xfer(d[i]);
    xfer(1'b1);
    if (s !== 1'b0) ok = 1'b0;
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    byte_out({addr, 1'b0}, ok);
    byte_out(p, ok);
    byte_out(d, ok);
    stop();
  endtask
  // pointer write, repeated start, one byte read with master nack
  task rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    byte_out({addr, 1'b0}, ok);
    byte_out(p, ok);
    start();
    byte_out({addr, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1);
      d[i] = s;
    end
    xfer(1'b1);
    stop();
  endtask
endmodule

/* File: tb/test_rail_enable_trim_regs.sv */
// self-checking bench for the rail enable and trim register bank
`timescale 1ns/1ps
module test_rail_enable_trim_regs;
  import retr_pkg::*;
  typedef struct {
    logic [7:0] en;
    logic [7:0] trim;
    logic [3:0] pins;
    logic [8:0] exp;
  } retr_row_s;
  logic       clock_i, rst_i, ce, scl, pull, sda, sda_o, sda_dn, int_o, int_dn, ok;
  logic [3:0] pins;
  logic [7:0] fault_ev, d;
  logic [2:0] uv_ev, pg;
  logic [8:0] rails;
  int         errors, checks;
  // rows: enable, trim, pins {apply,b1,b2,b3}, rails {bucks,ports,trim2,trim3}
  retr_row_s  rows [5] = '{
    '{8'hC0, 8'h0F, 4'h0, 9'h000}, '{8'h3C, 8'h06, 4'h0, 9'h1C6},
    '{8'h03, 8'h0D, 4'h8, 9'h03D}, '{8'h00, 8'h0C, 4'h5, 9'h140},
    '{8'h10, 8'h03, 4'hA, 9'h183}};
  assign sda = !pull && sda_dn;  // pulled-up wire
  retr_host u_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  retr_regs u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_drive_n_o(sda_dn), .first_buck_pin_i(pins[2]),
    .second_buck_pin_i(pins[1]), .third_buck_pin_i(pins[0]), .trim_apply_pin_i(pins[3]),
    .fault_event_i(fault_ev), .undervolt_event_i(uv_ev), .power_good_i(pg),
    .first_buck_on_o(rails[8]), .second_buck_on_o(rails[7]), .third_buck_on_o(rails[6]),
    .first_port_switch_on_o(rails[5]), .second_port_switch_on_o(rails[4]),
    .second_buck_trim_code_o(rails[3:2]), .third_buck_trim_code_o(rails[1:0]),
    .int_o(int_o), .int_drive_n_o(int_dn));
  // clock source
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = !clock_i;
  end
  task check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clock_i);
    errors++;
    summarize();
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    pins = 4'h0;
    fault_ev = 8'h00;
    uv_ev = 3'h0;
    pg = 3'h5;
    u_host.cyc(16);
    rst_i = 1'b0;
    u_host.cyc(6);
    for (int i = 0; i < 5; i++) begin
      pins = rows[i].pins;
      u_host.wr(ADDR_ENABLE, rows[i].en, ok);
      check(ok, 1'b1);
      u_host.wr(ADDR_TRIM, rows[i].trim, ok);
      u_host.rd(ADDR_ENABLE, d, ok);
      check(d, rows[i].en);
      u_host.rd(ADDR_TRIM, d, ok);
      check(d, rows[i].trim);
      check(rails, rows[i].exp);
    end
    // reset in mid-run
    pins = 4'h0;
    rst_i = 1'b1;
    u_host.cyc(2);
    check(rails, 9'h000);
    rst_i = 1'b0;
    u_host.cyc(6);
    // frozen clock enable holds the rails, release lets the pins through
    ce = 1'b0;
    pins = 4'h7;
    u_host.cyc(12);
    check(rails, 9'h000);
    ce = 1'b1;
    u_host.cyc(8);
    check(rails, 9'h1C0);
    pins = 4'h0;
    u_host.cyc(8);
    check(rails, 9'h000);
    // wrong device address, flag register write, unmapped read
    u_host.addr = 7'h2B;
    u_host.wr(ADDR_ENABLE, 8'hFF, ok);
    check(ok, 1'b0);
    u_host.addr = DEF_DEV_ADDR;
    u_host.wr(ADDR_FLAGS1, 8'hFF, ok);
    u_host.rd(ADDR_ENABLE, d, ok);
    check(d, 8'h00);
    u_host.rd(ADDR_FLAGS1, d, ok);
    check(d, 8'h00);
    u_host.rd(8'h07, d, ok);
    check(d, 8'h00);
    // raise flags, then clear them by reads
    fault_ev = 8'hA5;
    uv_ev = 3'h2;
    u_host.cyc(1);
    fault_ev = 8'h5A;
    uv_ev = 3'h5;
    u_host.cyc(1);
    fault_ev = 8'h00;
    uv_ev = 3'h0;
    u_host.cyc(3);
    check(int_dn, 1'b0);
    u_host.rd(ADDR_FLAGS1, d, ok);
    check(d, 8'hFF);
    u_host.rd(ADDR_FLAGS1, d, ok);
    check(d, 8'h00);
    check(int_dn, 1'b0);
    u_host.rd(ADDR_FLAGS2, d, ok);
    check(d, 8'h3D);
    // power good keeps tracking its live inputs
    pg = 3'h2;
    u_host.rd(ADDR_FLAGS2, d, ok);
    check(d, 8'h02);
    u_host.cyc(2);
    check(int_dn, 1'b1);
    check({sda_o, int_o}, 2'h0);
    summarize();
  end
endmodule
